/* bench/tcsw_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
// pin source and core side: external clock, capture input, wake and vector sink
module tcsw_far_model (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic wake_core, // wake pulse from timer
  input wire logic vector_req, // vector request from timer
  output logic ext_clk_pin, // external clock pin
  output logic capture_pin, // capture pin
  output logic [7:0] wake_count, // wakes seen
  output logic [7:0] vec_count // vector requests seen
);
  initial begin
    ext_clk_pin = 1'b0;
    capture_pin = 1'b0;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_count <= 8'h00;
      vec_count <= 8'h00;
    end else begin
      wake_count <= wake_core ? wake_count + 8'h01 : wake_count;
      vec_count <= vector_req ? vec_count + 8'h01 : vec_count;
    end
  end
  // slow pulses so the two-flop synchroniser sees each one
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge mclk) ext_clk_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_clk_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask
  task automatic cap_pulse();
    @(posedge mclk) capture_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    capture_pin <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tcsw_pkg::*;
  logic mclk, rstn, rd, wr, sleep_mode, ext_clk_pin, capture_pin, wake_core, vector_req, capcomp_event, irq, wreq;
  logic [3:0] addr, be;
  logic [1:0] sel;
  logic [31:0] wdata, rdata, seed;
  logic [12:0] vector_addr;
  logic [15:0] time_base;
  logic [7:0] wake_count, vec_count;
  logic [31:0] expq[$];
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  tcsw_timer tcsw_timer_inst (.mclk(mclk), .rstn(rstn), .avs_address(addr), .avs_select(sel),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .sleep_mode(sleep_mode), .ext_clk_pin(ext_clk_pin), .capture_pin(capture_pin),
    .wake_core(wake_core), .vector_req(vector_req), .vector_addr(vector_addr),
    .capcomp_event(capcomp_event), .time_base(time_base), .irq(irq));
  tcsw_far_model tcsw_far_model_inst (.mclk(mclk), .rstn(rstn), .wake_core(wake_core),
    .vector_req(vector_req), .ext_clk_pin(ext_clk_pin), .capture_pin(capture_pin),
    .wake_count(wake_count), .vec_count(vec_count));
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until the edge where waitrequest is low
  task automatic bus(input logic w, input logic [1:0] s, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    sel <= s;
    addr <= a;
    wdata <= d;
    be <= 4'h3;
    forever begin
      @(posedge mclk);
      if (wreq === 1'b0) break;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    // outputs are looked at only once settled
    @(negedge mclk);
  endtask
  task automatic wr_reg(input logic [1:0] s, input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, s, a, d);
  endtask
  task automatic rd_exp(input logic [1:0] s, input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, s, a, 32'h0);
  endtask
  // read results are taken off the queue as they complete
  always @(posedge mclk) begin
    if (rd === 1'b1 && wreq === 1'b0) begin
      if (expq.size() == 0) chk("unexpected read", 32'h0, 32'h1);
      else chk("read data", expq.pop_front(), rdata);
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    rstn = 1'b0;
    {rd, wr, sleep_mode} = 3'b000;
    sel = 2'h0;
    addr = 4'h0;
    be = 4'h0;
    wdata = 32'h0;
    seed = 32'h168f;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_CTRL, 32'h0);
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'h0);
    rd_exp(2'h1, 4'h8, 32'h0);
    $display("test reset done");
    // rollover at the maximum count
    wr_reg(2'h1, TCSW_OFF_IRQ_EN, 32'h1);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_CTRL, 32'h11);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'hfffe);
    tcsw_far_model_inst.ext_pulses(2);
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'h0);
    chk("irq", 32'h1, {31'h0, irq});
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_STATUS, 32'h1);
    wr_reg(2'h1, TCSW_OFF_IRQ_CLR, 32'hf);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test rollover done");
    // capture of a random count
    seed = xorshift(seed);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_CTRL, 32'h111);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_COUNT, {16'h0, seed[15:0] & 16'h7fff});
    chk("time base", {17'h0, seed[14:0]}, {16'h0, time_base});
    tcsw_far_model_inst.cap_pulse();
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_CAPCOMP, {17'h0, seed[14:0]});
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_STATUS, 32'h2);
    $display("test capture done");
    // special trigger turns the compare value into a period, synchronised counting
    wr_reg(2'h1, TCSW_OFF_IRQ_CLR, 32'hf);
    wr_reg(2'h1, TCSW_OFF_IRQ_EN, 32'h5);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_CAPCOMP, 32'h3);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'h0);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_CTRL, 32'h611);
    tcsw_far_model_inst.ext_pulses(3);
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'h0);
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_STATUS, 32'h4);
    chk("compare irq", 32'h1, {31'h0, irq});
    tcsw_far_model_inst.ext_pulses(2);
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'h2);
    $display("test special trigger done");
    // sleep: synchronised mode holds, asynchronous mode counts and wakes
    wr_reg(2'h1, TCSW_OFF_IRQ_CLR, 32'hf);
    wr_reg(2'h1, TCSW_OFF_IRQ_EN, 32'h9);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_CTRL, 32'h11);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'h5);
    @(posedge mclk) sleep_mode <= 1'b1;
    tcsw_far_model_inst.ext_pulses(2);
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'h5);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_CTRL, 32'hff);
    wr_reg(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'hffff);
    tcsw_far_model_inst.ext_pulses(1);
    chk("wake count", 32'h1, {24'h0, wake_count});
    chk("vector count", 32'h1, {24'h0, vec_count});
    chk("vector addr", 32'h4, {19'h0, vector_addr});
    @(posedge mclk) sleep_mode <= 1'b0;
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_COUNT, 32'h0);
    rd_exp(TCSW_SEL_MAIN, TCSW_OFF_STATUS, 32'h9);
    rd_exp(2'h1, TCSW_OFF_IRQ_EN, 32'h9);
    chk("wake irq", 32'h1, {31'h0, irq});
    $display("test sleep done");
    repeat (4) @(posedge mclk);
    chk("queue empty", 32'h0, expq.size());
    stop_test();
  end
endmodule
`default_nettype wire

/* verilog/tcsw_edge.sv */
`timescale 1ns/100ps
`default_nettype none
module tcsw_edge (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic level, // synchronised level
  output logic rise // one-cycle pulse on rising edge
);
  logic last;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end
  assign rise = level & ~last;
endmodule
`default_nettype wire

/* verilog/tcsw_pkg.sv */
package tcsw_pkg;
  // register word offsets (byte addresses)
  localparam logic [3:0] TCSW_OFF_CTRL    = 4'h0;
  localparam logic [3:0] TCSW_OFF_COUNT   = 4'h4;
  localparam logic [3:0] TCSW_OFF_CAPCOMP = 4'h8;
  localparam logic [3:0] TCSW_OFF_STATUS  = 4'hc;
  localparam logic [3:0] TCSW_OFF_IRQ_EN  = 4'h0;
  localparam logic [3:0] TCSW_OFF_IRQ_CLR = 4'h4;
  localparam logic [1:0] TCSW_SEL_MAIN = 2'h0;
  // control field positions
  localparam int TCSW_CTL_RUN = 0;
  localparam int TCSW_CTL_OVF_IE = 1;
  localparam int TCSW_CTL_PERI_IE = 2;
  localparam int TCSW_CTL_SYNC_DIS = 3;
  localparam int TCSW_CTL_CLKSRC = 4;
  localparam int TCSW_CTL_XTAL_EN = 5;
  localparam int TCSW_CTL_GATE_IE = 6;
  localparam int TCSW_CTL_GLOBAL_IE = 7;
  localparam int TCSW_CTL_MODE_LO = 8;
  localparam int TCSW_CTL_SPECIAL = 10;
  localparam int TCSW_CTL_CAP_RISE = 11;
  localparam int TCSW_CTL_WIDTH = 12;
  localparam logic [11:0] TCSW_CTL_RESET = 12'h000;
  localparam logic [15:0] TCSW_COUNT_RESET = 16'h0000;
  localparam logic [15:0] TCSW_COUNT_MAX = 16'hffff;
  // status bit positions
  localparam int TCSW_ST_OVF = 0;
  localparam int TCSW_ST_CAPTURE = 1;
  localparam int TCSW_ST_COMPARE = 2;
  localparam int TCSW_ST_WAKE = 3;
  localparam int TCSW_NUM_EVT = 4;
  // wake vector address
  localparam logic [12:0] TCSW_IRQ_VECTOR = 13'h0004;
  typedef enum logic [1:0] {TCSW_MODE_OFF, TCSW_MODE_CAPTURE, TCSW_MODE_COMPARE} tcsw_mode_t;
  typedef enum {TCSW_BUS_IDLE, TCSW_BUS_ACK} tcsw_bus_t;
endpackage

/* verilog/tcsw_sync2.sv */
`timescale 1ns/100ps
`default_nettype none
module tcsw_sync2 (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic din, // asynchronous level
  output logic dout // synchronised level
);
  logic stage1;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule
`default_nettype wire

/* verilog/tcsw_timer.sv */
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - counting continues in sleep only in asynchronous external counter mode.
// - asynchronous mode counts edges of the external crystal or clock input.
// - overflow in sleep with wake enabled wakes core at next instruction.
// - after wake with global enable set, core vectors to address 0004h.
// - the 16-bit count is the capture/compare time base.
// - capture event copies the count into the value register pair.
// - compare raises an event when value pair equals the count.
// - outside asynchronous mode, special trigger clears both count bytes.
// - special trigger clear never sets the overflow flag.
// - capture/compare keeps its own interrupt on the special trigger match.
// - with special trigger outside asynchronous mode, the value pair acts as the timer period.
// - a software count write wins over a coincident special trigger clear.
// - count rolls FFFFh to 0000h, setting the overflow flag each time.
module tcsw_timer
  import tcsw_pkg::*;
(
  input wire logic mclk, // 10 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic [3:0] avs_address, // byte address
  input wire logic [1:0] avs_select, // 0: main bank, 1: interrupt bank
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic sleep_mode, // core asleep
  input wire logic ext_clk_pin, // external crystal or clock pin
  input wire logic capture_pin, // capture input pin
  output logic wake_core, // wake pulse to core
  output logic vector_req, // request jump to vector
  output logic [12:0] vector_addr, // vector address
  output logic capcomp_event, // compare match pulse
  output logic [15:0] time_base, // count to capture/compare unit
  output logic irq // level interrupt
);
  logic [TCSW_CTL_WIDTH-1:0] ctrl;
  logic [15:0] count;
  logic [15:0] capcomp;
  logic [TCSW_NUM_EVT-1:0] status;
  logic [TCSW_NUM_EVT-1:0] irq_en;
  tcsw_bus_t bus_state;
  logic ext_sync, ext_rise, cap_sync, cap_rise;
  logic [15:0] cmp_prev;
  logic cmp_armed;

  tcsw_sync2 u_ext_sync (.mclk(mclk), .rstn(rstn), .din(ext_clk_pin), .dout(ext_sync));
  tcsw_edge u_ext_edge (.mclk(mclk), .rstn(rstn), .level(ext_sync), .rise(ext_rise));
  tcsw_sync2 u_cap_sync (.mclk(mclk), .rstn(rstn), .din(capture_pin), .dout(cap_sync));
  tcsw_edge u_cap_edge (.mclk(mclk), .rstn(rstn), .level(cap_sync), .rise(cap_rise));

  // control decode
  wire run_en = ctrl[TCSW_CTL_RUN];
  wire ovf_ie = ctrl[TCSW_CTL_OVF_IE];
  wire peri_ie = ctrl[TCSW_CTL_PERI_IE];
  wire sync_disable = ctrl[TCSW_CTL_SYNC_DIS];
  wire ext_src = ctrl[TCSW_CTL_CLKSRC];
  wire global_ie = ctrl[TCSW_CTL_GLOBAL_IE];
  wire special_en = ctrl[TCSW_CTL_SPECIAL];
  wire [1:0] mode_bits = ctrl[TCSW_CTL_MODE_LO +: 2];
  wire mode_capture = (mode_bits == 2'(TCSW_MODE_CAPTURE));
  wire mode_compare = (mode_bits == 2'(TCSW_MODE_COMPARE));
  wire async_mode = ext_src & sync_disable;

  // count enable: sleep stops all but asynchronous external counting
  wire src_tick = ext_src ? ext_rise : 1'b1;
  wire count_tick = run_en & src_tick & (~sleep_mode | async_mode);
  wire at_max = (count == TCSW_COUNT_MAX);
  wire overflow = count_tick & at_max;

  // bus decode
  wire bus_req = (avs_read | avs_write) & (bus_state == TCSW_BUS_IDLE);
  // writes land at the edge where waitrequest is seen low, as the master expects
  wire wr_go = avs_write & (bus_state == TCSW_BUS_ACK);
  wire main_bank = (avs_select == TCSW_SEL_MAIN);
  wire wr_ctrl = wr_go & main_bank & (avs_address == TCSW_OFF_CTRL);
  wire wr_count = wr_go & main_bank & (avs_address == TCSW_OFF_COUNT);
  wire wr_capcomp = wr_go & main_bank & (avs_address == TCSW_OFF_CAPCOMP);
  wire wr_irq_en = wr_go & ~main_bank & (avs_address == TCSW_OFF_IRQ_EN);
  wire wr_irq_clr = wr_go & ~main_bank & (avs_address == TCSW_OFF_IRQ_CLR);
  wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // compare: one pulse per new equality
  wire cmp_equal = mode_compare & (capcomp == count);
  wire cmp_pulse = cmp_equal & (~cmp_armed | (cmp_prev != count));
  wire special_trig = cmp_pulse & special_en & ~async_mode;
  wire cap_event = mode_capture & cap_rise;
  wire wake_evt = overflow & sleep_mode & run_en & ovf_ie & peri_ie;

  wire [15:0] count_merged = (count & ~be_mask) | (avs_writedata[15:0] & be_mask);
  logic [15:0] next_count;
  always_comb begin
    next_count = count;
    if (count_tick) begin
      next_count = 16'(count + 16'h0001);
    end
    if (special_trig) begin
      next_count = TCSW_COUNT_RESET;
    end
    if (wr_count) begin
      next_count = count_merged;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count <= TCSW_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_prev <= TCSW_COUNT_RESET;
      cmp_armed <= 1'b0;
    end else begin
      cmp_prev <= count;
      cmp_armed <= cmp_equal;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= TCSW_CTL_RESET;
    end else if (wr_ctrl) begin
      if (avs_byteenable[0]) ctrl[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) ctrl[11:8] <= avs_writedata[11:8];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      capcomp <= TCSW_COUNT_RESET;
    end else if (cap_event) begin
      capcomp <= count;
    end else if (wr_capcomp) begin
      capcomp <= (capcomp & ~be_mask) | (avs_writedata[15:0] & be_mask);
    end
  end

  // sticky events: set beats clear; trigger clear cannot set overflow
  wire [TCSW_NUM_EVT-1:0] evt_set = {wake_evt, cmp_pulse, cap_event, overflow};
  wire [TCSW_NUM_EVT-1:0] clr_mask = wr_irq_clr ? avs_writedata[TCSW_NUM_EVT-1:0] : '0;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
      irq_en <= '0;
    end else begin
      status <= (status & ~clr_mask) | evt_set;
      if (wr_irq_en) irq_en <= avs_writedata[TCSW_NUM_EVT-1:0];
    end
  end
  assign irq = |(status & irq_en);

  // wake and vector request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_core <= 1'b0;
      vector_req <= 1'b0;
    end else begin
      wake_core <= wake_evt;
      vector_req <= wake_evt & global_ie;
    end
  end
  assign vector_addr = TCSW_IRQ_VECTOR;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      capcomp_event <= 1'b0;
      time_base <= TCSW_COUNT_RESET;
    end else begin
      capcomp_event <= cmp_pulse;
      time_base <= next_count;
    end
  end

  // bus: one wait cycle, answer in the following cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (main_bank) begin
      case (avs_address)
        TCSW_OFF_CTRL: rd_mux = {20'h00000, ctrl};
        TCSW_OFF_COUNT: rd_mux = {16'h0000, count};
        TCSW_OFF_CAPCOMP: rd_mux = {16'h0000, capcomp};
        TCSW_OFF_STATUS: rd_mux = {28'h0000000, status};
        default: rd_mux = 32'h0000_0000;
      endcase
    end else if (avs_address == TCSW_OFF_IRQ_EN) begin
      rd_mux = {28'h0000000, irq_en};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus_state <= TCSW_BUS_IDLE;
      avs_readdata <= 32'h0000_0000;
    end else begin
      case (bus_state)
        TCSW_BUS_IDLE: begin
          if (bus_req) begin
            bus_state <= TCSW_BUS_ACK;
            avs_readdata <= rd_mux;
          end
        end
        TCSW_BUS_ACK: bus_state <= TCSW_BUS_IDLE;
        default: bus_state <= TCSW_BUS_IDLE;
      endcase
    end
  end
  assign avs_waitrequest = ~(bus_state == TCSW_BUS_ACK);

  // checks
  a_sleep_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (sleep_mode & ~async_mode & ~wr_count & ~special_trig) |=> ($stable(count) || $past(wr_count)))
    else $error("count moved in sleep outside async mode");
  a_rollover_flag: assert property (@(posedge mclk) disable iff (!rstn)
    overflow |=> (count == 16'h0000) && status[TCSW_ST_OVF])
    else $error("rollover did not zero count and set flag");
  a_trig_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (special_trig & ~wr_count) |=> (count == 16'h0000))
    else $error("special trigger did not clear count");
  a_trig_noovf: assert property (@(posedge mclk) disable iff (!rstn)
    (special_trig & ~overflow & ~status[TCSW_ST_OVF] & ~wr_irq_clr) |=> ~status[TCSW_ST_OVF])
    else $error("special trigger set overflow flag");
  a_write_wins: assert property (@(posedge mclk) disable iff (!rstn)
    (wr_count & special_trig & (avs_byteenable[1:0] == 2'b11)) |=> (count == $past(avs_writedata[15:0])))
    else $error("count write lost to trigger");
  a_capture_copy: assert property (@(posedge mclk) disable iff (!rstn)
    cap_event |=> (capcomp == $past(count)))
    else $error("capture did not copy count");
  a_cmp_single: assert property (@(posedge mclk) disable iff (!rstn)
    capcomp_event |=> ~capcomp_event || $changed(time_base))
    else $error("compare pulse repeated without count change");
  a_wake_vector: assert property (@(posedge mclk) disable iff (!rstn)
    wake_evt |=> wake_core && (vector_req == $past(global_ie)))
    else $error("wake or vector missing");
  a_vector_only: assert property (@(posedge mclk) disable iff (!rstn)
    vector_req |-> wake_core && (vector_addr == 13'h0004))
    else $error("vector without wake");
  a_base_match: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> (time_base == count))
    else $error("time base differs from count");
  a_capcomp_irq: assert property (@(posedge mclk) disable iff (!rstn)
    cmp_pulse |=> status[TCSW_ST_COMPARE])
    else $error("compare flag missing");
  c_wake: cover property (@(posedge mclk) disable iff (!rstn) wake_evt ##1 vector_req);
  c_period: cover property (@(posedge mclk) disable iff (!rstn) special_trig ##[1:50] special_trig);
  c_capture: cover property (@(posedge mclk) disable iff (!rstn) cap_event);
  c_clash: cover property (@(posedge mclk) disable iff (!rstn) wr_count & special_trig);
endmodule
`default_nettype wire
